/* logic/sbr_cfg.svh */
// Register map, field positions and divider limits for the bit-rate and receive-mirror block.
// Assumes it is included by bare name wherever the block's logic needs these figures.
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH

// Register addresses on the plain register port
`define SBR_ADDR_CTL    16'h7041
`define SBR_ADDR_STS    16'h7042
`define SBR_ADDR_BRR    16'h7044
`define SBR_ADDR_MIRROR 16'h7046
`define SBR_ADDR_RXBUF  16'h7047
`define SBR_ADDR_SHIFT  16'h7049
`define SBR_ADDR_EVT    16'h7050
`define SBR_ADDR_MASK   16'h7051

// Field positions
`define SBR_CTL_IE      0
`define SBR_CTL_MASTER  2
`define SBR_STS_RXC     6
`define SBR_STS_OVR     7
`define SBR_BRR_TOP     7
`define SBR_EVT_RXC     0
`define SBR_EVT_OVR     1

// Reset values
`define SBR_RST_BRR     7'h00
`define SBR_RST_RXBUF   16'h0000

// Divider limits: below the minimum the period is fixed
`define SBR_BRR_MIN     3
`define SBR_SLOW_PER    4

`endif

/* logic/sbr_pkg.sv */
// Types shared by the bit-rate and receive-mirror block.
// Assumes the constants header supplies all addresses and field positions.
package sbr_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } sbr_bus_s;

  typedef struct packed {
    logic rise;
    logic fall;
  } sbr_tick_s;

  typedef enum logic [1:0] {
    SBR_IDLE  = 2'h0,
    SBR_SHIFT = 2'h1,
    SBR_TAIL  = 2'h3
  } sbr_state_e;

endpackage

/* logic/sbr_clk_div.sv */
// Serial bit-clock divider: rise and fall enables at the selected bit rate.
// Assumes one system clock; runs only while a master transfer is in SBR_SHIFT or SBR_TAIL.
`include "sbr_cfg.svh"

module sbr_clk_div
  import sbr_pkg::*;
#(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_div,
  // Enables
  output sbr_tick_s             o_tick
);

  if (DIV_W < 2 || DIV_W > 7) begin : g_bad_width
    $error("sbr_clk_div: DIV_W must lie in 2..7");
  end

  logic [DIV_W:0] per;
  logic [DIV_W:0] lo;
  logic [DIV_W:0] cnt_q;
  logic [DIV_W:0] cnt_d;
  logic           wrap;

  // Small divisors fall back to a fixed period of four
  assign per  = (i_div < DIV_W'(`SBR_BRR_MIN)) ? (DIV_W+1)'(`SBR_SLOW_PER)
                                                : {1'b0, i_div} + (DIV_W+1)'(1);
  // Odd periods keep the clock low one cycle longer than high
  assign lo   = per - (per >> 1);
  assign wrap = cnt_q >= per - (DIV_W+1)'(1);

  assign cnt_d = !i_run ? '0 : (wrap ? '0 : cnt_q + (DIV_W+1)'(1));
  assign o_tick.rise = i_run && (cnt_q == lo - (DIV_W+1)'(1));
  assign o_tick.fall = i_run && wrap;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  logic [DIV_W:0] gap_q;
  logic           seen_q;
  logic [DIV_W:0] per_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
      per_q  <= '0;
    end else begin
      per_q  <= per;
      gap_q  <= o_tick.rise ? (DIV_W+1)'(1) : gap_q + (DIV_W+1)'(1);
      seen_q <= i_run && (per == per_q) && (seen_q || o_tick.rise);
    end
  end

  a_div_rise_gap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_tick.rise && seen_q && per == per_q) |-> (gap_q == per))
    else $error("bit clock period differs from divisor");

  a_div_min_four: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_tick.rise |=> !o_tick.rise [*3])
    else $error("bit clock faster than a quarter of system clock");

endmodule

/* logic/sbr_top.sv */
// Bit-rate divider, receive shifter and side-effect-free receive mirror.
// Assumes a plain register port and serial pins synchronous to i_clk_sys.
//
// The address-and-strobe port was chosen for this implementation.
`include "sbr_cfg.svh"

module sbr_top
  import sbr_pkg::*;
#(
  parameter int CHAR_BITS = 8,
  parameter int DIV_W     = 7
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Register port
  input  sbr_bus_s         i_bus,
  output logic [15:0]      o_rdata,
  // Serial clock pin
  input  wire logic        i_sclk,
  output logic             o_sclk,
  output logic             o_sclk_oe,
  // Serial data pins
  input  wire logic        i_sdi,
  output logic             o_sdo,
  // Interrupt
  output logic             o_irq
);

  if (CHAR_BITS < 2 || CHAR_BITS > 16) begin : g_bad_char
    $error("sbr_top: CHAR_BITS must lie in 2..16");
  end

  localparam int CW = $clog2(CHAR_BITS);

  // Address decode
  wire hit_ctl    = i_bus.addr == `SBR_ADDR_CTL;
  wire hit_sts    = i_bus.addr == `SBR_ADDR_STS;
  wire hit_brr    = i_bus.addr == `SBR_ADDR_BRR;
  wire hit_mirror = i_bus.addr == `SBR_ADDR_MIRROR;
  wire hit_rxbuf  = i_bus.addr == `SBR_ADDR_RXBUF;
  wire hit_shift  = i_bus.addr == `SBR_ADDR_SHIFT;
  wire hit_evt    = i_bus.addr == `SBR_ADDR_EVT;
  wire hit_mask   = i_bus.addr == `SBR_ADDR_MASK;

  wire wr_ctl    = i_bus.wr && hit_ctl;
  wire wr_sts    = i_bus.wr && hit_sts;
  wire wr_brr    = i_bus.wr && hit_brr;
  wire wr_shift  = i_bus.wr && hit_shift;
  wire wr_evt    = i_bus.wr && hit_evt;
  wire wr_mask   = i_bus.wr && hit_mask;
  wire rd_rxbuf  = i_bus.rd && hit_rxbuf;
  wire rd_mirror = i_bus.rd && hit_mirror;

  // State
  logic                 ie_q;
  logic                 master_q;
  logic [DIV_W-1:0]     brr_q;
  logic [15:0]          rxbuf_q;
  logic                 rx_flag_q;
  logic                 ovr_q;
  logic [CHAR_BITS-1:0] shift_q;
  logic [CHAR_BITS-1:0] shift_d;
  logic [CW-1:0]        bitcnt_q;
  logic [CW-1:0]        bitcnt_d;
  sbr_state_e           state_q;
  sbr_state_e           state_d;
  logic                 sclk_in_q;
  logic                 sclk_q;
  logic                 sclk_oe_q;
  logic                 sdo_q;
  logic [1:0]           evt_q;
  logic [1:0]           mask_q;
  logic [15:0]          rdata_q;
  logic [15:0]          rdata_d;
  logic                 irq_q;
  sbr_tick_s            tick;

  sbr_clk_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (master_q && state_q != SBR_IDLE),
    .i_div     (brr_q),
    .o_tick    (tick)
  );

  // Bit strobes: divider in master mode, pin edge in slave mode
  // Pin edge detect needs the far clock at a quarter of ours or below
  wire slave_rise  = !master_q && i_sclk && !sclk_in_q;
  wire master_rise = master_q && state_q == SBR_SHIFT && tick.rise;
  wire bit_rise    = master_rise || slave_rise;
  wire last_bit    = bitcnt_q == CW'(CHAR_BITS - 1);
  wire rx_done     = bit_rise && last_bit;

  wire [CHAR_BITS-1:0] shift_next = {shift_q[CHAR_BITS-2:0], i_sdi};

  // A new character over an unread one is an overrun
  wire ovr_set  = rx_done && rx_flag_q && !rd_rxbuf;
  wire sts_wr1c = wr_sts && i_bus.wdata[`SBR_STS_OVR];

  // Transfer sequencing
  // A write while a master transfer runs is dropped
  wire load_ok = wr_shift && state_q == SBR_IDLE;

  always_comb begin
    state_d  = state_q;
    shift_d  = shift_q;
    bitcnt_d = bitcnt_q;
    if (load_ok) begin
      shift_d  = i_bus.wdata[15 -: CHAR_BITS];
      bitcnt_d = '0;
    end else if (bit_rise) begin
      shift_d  = shift_next;
      bitcnt_d = last_bit ? '0 : bitcnt_q + CW'(1);
    end
    case (state_q)
      SBR_IDLE: begin
        if (load_ok && master_q) begin
          state_d = SBR_SHIFT;
        end
      end
      SBR_SHIFT: begin
        if (rx_done) begin
          state_d = SBR_TAIL;
        end
      end
      SBR_TAIL: begin
        if (tick.fall) begin
          state_d = SBR_IDLE;
        end
      end
      default: begin
        state_d = SBR_IDLE;
      end
    endcase
  end

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (!i_bus.rd) begin
      rdata_d = 16'h0000;
    end else if (hit_ctl) begin
      rdata_d[`SBR_CTL_IE]     = ie_q;
      rdata_d[`SBR_CTL_MASTER] = master_q;
    end else if (hit_sts) begin
      rdata_d[`SBR_STS_RXC] = rx_flag_q;
      rdata_d[`SBR_STS_OVR] = ovr_q;
    end else if (hit_brr) begin
      rdata_d[DIV_W-1:0] = brr_q;
    end else if (hit_mirror || hit_rxbuf) begin
      rdata_d = rxbuf_q;
    end else if (hit_evt) begin
      rdata_d[1:0] = evt_q;
    end else if (hit_mask) begin
      rdata_d[1:0] = mask_q;
    end
  end

  // Control and divider registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ie_q     <= 1'b0;
      master_q <= 1'b0;
      brr_q    <= `SBR_RST_BRR;
      mask_q   <= 2'h0;
    end else begin
      if (wr_ctl && state_q == SBR_IDLE) begin
        ie_q     <= i_bus.wdata[`SBR_CTL_IE];
        master_q <= i_bus.wdata[`SBR_CTL_MASTER];
      end else if (wr_ctl) begin
        ie_q <= i_bus.wdata[`SBR_CTL_IE];
      end
      if (wr_brr) begin
        brr_q <= i_bus.wdata[DIV_W-1:0];
      end
      if (wr_mask) begin
        mask_q <= i_bus.wdata[1:0];
      end
    end
  end

  // Shifter and sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q   <= SBR_IDLE;
      shift_q   <= '0;
      bitcnt_q  <= '0;
      sclk_in_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      shift_q   <= shift_d;
      bitcnt_q  <= bitcnt_d;
      sclk_in_q <= i_sclk;
    end
  end

  // Receive buffer and flags; a set in the same cycle beats a clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rxbuf_q   <= `SBR_RST_RXBUF;
      rx_flag_q <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      if (rx_done) begin
        rxbuf_q   <= 16'(shift_next);
        rx_flag_q <= 1'b1;
      end else if (rd_rxbuf) begin
        rx_flag_q <= 1'b0;
      end
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (sts_wr1c) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Event status, write one to clear, set wins
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      evt_q <= 2'h0;
    end else begin
      evt_q[`SBR_EVT_RXC] <= rx_done ||
                             (evt_q[`SBR_EVT_RXC] && !(wr_evt && i_bus.wdata[`SBR_EVT_RXC]));
      evt_q[`SBR_EVT_OVR] <= ovr_set ||
                             (evt_q[`SBR_EVT_OVR] && !(wr_evt && i_bus.wdata[`SBR_EVT_OVR]));
    end
  end

  // Pin and port outputs, all registered
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
      sdo_q     <= 1'b0;
      rdata_q   <= 16'h0000;
      irq_q     <= 1'b0;
    end else begin
      if (master_rise) begin
        sclk_q <= 1'b1;
      end else if (tick.fall || !master_q) begin
        sclk_q <= 1'b0;
      end
      sclk_oe_q <= master_q;
      sdo_q     <= shift_d[CHAR_BITS-1];
      rdata_q   <= rdata_d;
      irq_q     <= (rx_flag_q && ie_q) || |(evt_q & mask_q);
    end
  end

  assign o_sclk    = sclk_q;
  assign o_sclk_oe = sclk_oe_q;
  assign o_sdo     = sdo_q;
  assign o_rdata   = rdata_q;
  assign o_irq     = irq_q;

  a_brr_top_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_bus.rd && hit_brr) |=> (o_rdata[`SBR_BRR_TOP] == 1'b0 && o_rdata[15:8] == 8'h00))
    else $error("divider top bit read back non-zero");

  a_brr_field_store: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_brr ##1 (i_bus.rd && hit_brr && !wr_brr) |=> (o_rdata[DIV_W-1:0] == $past(brr_q)))
    else $error("divisor field did not read back");

  a_bit_per_rise: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (bit_rise && !load_ok && !last_bit) |=> (bitcnt_q == $past(bitcnt_q) + CW'(1)))
    else $error("bit count did not advance by one");

  a_master_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    master_rise |=> (o_sclk && o_sclk_oe))
    else $error("master clock not driven out");

  a_slave_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !master_q |=> (!o_sclk_oe && !o_sclk))
    else $error("slave drove the clock pin");

  a_done_sets_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rx_done |=> (rx_flag_q && rxbuf_q == 16'($past(shift_next))))
    else $error("character and flag not set together");

  a_buf_read_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_rxbuf && !rx_done) |=> (!rx_flag_q && o_rdata == $past(rxbuf_q)))
    else $error("buffer read did not clear flag");

  a_mirror_keeps: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_mirror && !rx_done && !ovr_set && !sts_wr1c)
      |=> (rx_flag_q == $past(rx_flag_q) && ovr_q == $past(ovr_q) && o_rdata == $past(rxbuf_q)))
    else $error("mirror read disturbed state");

  a_mirror_alias: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_mirror ##1 (i_bus.rd && hit_rxbuf)) |=> (o_rdata == $past(o_rdata) || $past(rx_done, 2) || $past(rx_done)))
    else $error("mirror and buffer disagree");

  a_irq_request: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rx_flag_q && ie_q) |=> o_irq)
    else $error("enabled flag did not request interrupt");

  a_mirror_no_shift: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_mirror && !bit_rise && !load_ok) |=> (shift_q == $past(shift_q) && evt_q == $past(evt_q)))
    else $error("mirror read changed buffers");

endmodule

/* tb/sbr_peer.sv */
// Serial peer model: follows the block's clock as a target, or makes one as an external master.
// Assumes it shares the system clock and sees the resolved level of the clock pin.
module sbr_peer (
  // Clock
  input  wire logic i_clk_sys,
  // Serial pins
  input  wire logic i_sclk,
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_sdi
);
  logic [7:0] tx        = 8'h00;
  logic [7:0] rx        = 8'h00;
  logic       busy      = 1'b0;
  logic       sclk_prev = 1'b0;
  logic       sdo_prev  = 1'b0;
  int         half      = 0;
  int         nbit      = 0;
  int         cnt       = 0;

  initial begin
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end

  // Half period zero follows the pin clock instead of making one
  task automatic start(input logic [7:0] d, input int h);
    tx   <= d;
    half <= h;
    nbit <= 0;
    cnt  <= 0;
    busy <= 1'b1;
  endtask

  always @(posedge i_clk_sys) begin
    sclk_prev <= i_sclk;
    sdo_prev  <= i_sdo;
    if (!busy) begin
      // Clock stands low between frames; data never holds a stale bit
      o_sclk <= 1'b0;
      o_sdi  <= ~o_sdi;
    end else if (half == 0) begin
      o_sdi <= tx[3'(7 - nbit)];
      if (i_sclk && !sclk_prev) begin
        rx   <= {rx[6:0], sdo_prev};
        nbit <= nbit + 1;
        busy <= (nbit < 7);
      end
    end else begin
      if (!o_sclk) begin
        o_sdi <= tx[3'(7 - nbit)];
      end
      if (cnt < half - 1) begin
        cnt <= cnt + 1;
      end else begin
        // Each level held at least two cycles keeps the rate at a quarter or less
        cnt    <= 0;
        o_sclk <= ~o_sclk;
        if (!o_sclk) begin
          rx <= {rx[6:0], i_sdo};
        end else begin
          nbit <= nbit + 1;
          busy <= (nbit < 7);
        end
      end
    end
  end
endmodule

/* tb/sbr_top_tb.sv */
// Self-checking bench for the bit-rate divider and receive mirror block.
// Assumes the serial peer model on the far side of the pins.
`include "sbr_cfg.svh"

module sbr_top_tb
  import sbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'b0;
  logic        rst;
  sbr_bus_s    bus;
  logic [15:0] rdata;
  logic        sclk_out, sclk_oe, peer_sclk, sdi, sdo, irq, sclk_pin;
  logic        sclk_prev = 1'b0;
  int          errors = 0, num_checks = 0;
  int          cyc = 0, last_rise = 0, rises = 0, per_min = 0, per_max = 0;
  logic [6:0]  divs [6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h06, 7'h7f};

  // Shared clock pin resolved from both parties
  assign sclk_pin = sclk_oe ? sclk_out : peer_sclk;

  sbr_top u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .i_sclk(sclk_pin),
                 .o_sclk(sclk_out), .o_sclk_oe(sclk_oe), .i_sdi(sdi), .o_sdo(sdo), .o_irq(irq));
  sbr_peer u_peer (.i_clk_sys(clk_sys), .i_sclk(sclk_pin), .i_sdo(sdo), .o_sclk(peer_sclk), .o_sdi(sdi));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Period of the block's serial clock, rise to rise
  always @(posedge clk_sys) begin
    cyc       <= cyc + 1;
    sclk_prev <= sclk_out;
    if (sclk_out && !sclk_prev) begin
      rises     <= rises + 1;
      last_rise <= cyc;
      if (rises > 0) begin
        per_min <= (cyc - last_rise < per_min) ? cyc - last_rise : per_min;
        per_max <= (cyc - last_rise > per_max) ? cyc - last_rise : per_max;
      end
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask

  task automatic wait_peer();
    int n;
    n = 0;
    @(posedge clk_sys);
    while ((u_peer.busy !== 1'b0 || sclk_out !== 1'b0) && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      $display("BAD serial transfer never finished");
      complete_run();
    end
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic master_xfer(input logic [6:0] div, input logic [7:0] tx, input logic [7:0] rx);
    int p;
    p = (div < 3) ? 4 : int'(div) + 1;
    wr(`SBR_ADDR_BRR, {9'h000, div});
    rises   <= 0;
    per_min <= 999;
    per_max <= 0;
    u_peer.start(rx, 0);
    wr(`SBR_ADDR_SHIFT, {tx, 8'h00});
    wait_peer();
    chk("rise count", 16'(rises), 16'h0008);
    chk("period min", 16'(per_min), 16'(p));
    chk("period max", 16'(per_max), 16'(p));
    chk("peer rx", {8'h00, u_peer.rx}, {8'h00, tx});
    chk("clock drive", {15'h0000, sclk_oe}, 16'h0001);
  endtask

  initial begin
    bus = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rchk("divider reset", `SBR_ADDR_BRR, 16'h0000);
    rchk("mirror reset", `SBR_ADDR_MIRROR, 16'h0000);
    rchk("unmapped", 16'h7043, 16'h0000);
    wr(`SBR_ADDR_BRR, 16'h00ff);
    rchk("divider top", `SBR_ADDR_BRR, 16'h007f);
    wr(`SBR_ADDR_MIRROR, 16'h1234);
    rchk("mirror ro", `SBR_ADDR_MIRROR, 16'h0000);
    wr(`SBR_ADDR_CTL, 16'h0005);
    foreach (divs[i]) begin
      master_xfer(divs[i], 8'h96 ^ 8'(i), 8'h5a + 8'(i));
      chk("irq set", {15'h0000, irq}, 16'h0001);
      rchk("status set", `SBR_ADDR_STS, 16'h0040);
      rchk("mirror", `SBR_ADDR_MIRROR, {8'h00, 8'h5a + 8'(i)});
      rchk("status kept", `SBR_ADDR_STS, 16'h0040);
      rchk("buffer", `SBR_ADDR_RXBUF, {8'h00, 8'h5a + 8'(i)});
      rchk("status clear", `SBR_ADDR_STS, 16'h0000);
      chk("irq clear", {15'h0000, irq}, 16'h0000);
    end
    // Two characters unread give an overrun that mirror reads must not disturb
    wr(`SBR_ADDR_EVT, 16'h0003);
    master_xfer(7'h00, 8'h11, 8'hc3);
    master_xfer(7'h00, 8'h22, 8'h3c);
    rchk("overrun", `SBR_ADDR_STS, 16'h00c0);
    rchk("mirror latest", `SBR_ADDR_MIRROR, 16'h003c);
    rchk("overrun kept", `SBR_ADDR_STS, 16'h00c0);
    rchk("events", `SBR_ADDR_EVT, 16'h0003);
    rchk("buffer latest", `SBR_ADDR_RXBUF, 16'h003c);
    rchk("overrun only", `SBR_ADDR_STS, 16'h0080);
    wr(`SBR_ADDR_STS, 16'h0080);
    rchk("overrun cleared", `SBR_ADDR_STS, 16'h0000);
    // Event interrupt: masked, unmasked, cleared
    wr(`SBR_ADDR_CTL, 16'h0004);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr(`SBR_ADDR_MASK, 16'h0001);
    rchk("mask", `SBR_ADDR_MASK, 16'h0001);
    chk("irq unmasked", {15'h0000, irq}, 16'h0001);
    wr(`SBR_ADDR_EVT, 16'h0001);
    rchk("event cleared", `SBR_ADDR_EVT, 16'h0002);
    chk("irq gone", {15'h0000, irq}, 16'h0000);
    wr(`SBR_ADDR_MASK, 16'h0000);
    // Slave: divisor set but must not matter
    wr(`SBR_ADDR_CTL, 16'h0001);
    wr(`SBR_ADDR_BRR, 16'h0003);
    for (int h = 2; h <= 5; h += 3) begin
      rises <= 0;
      wr(`SBR_ADDR_SHIFT, {8'ha5 ^ 8'(h), 8'h00});
      u_peer.start(8'h3c + 8'(h), h);
      wait_peer();
      chk("slave no drive", {15'h0000, sclk_oe}, 16'h0000);
      chk("slave rises", 16'(rises), 16'h0000);
      chk("slave peer rx", {8'h00, u_peer.rx}, {8'h00, 8'ha5 ^ 8'(h)});
      chk("slave irq", {15'h0000, irq}, 16'h0001);
      rchk("slave mirror", `SBR_ADDR_MIRROR, {8'h00, 8'h3c + 8'(h)});
      rchk("slave buffer", `SBR_ADDR_RXBUF, {8'h00, 8'h3c + 8'(h)});
    end
    complete_run();
  end
endmodule
